// ### hw/dis_ext_edge.sv
// Synchroniser and edge detector for the external interrupt pins
`timescale 1ns/1ps

module dis_ext_edge #(
  parameter int unsigned PINS = dis_pkg::EXT_PINS
) (
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  input  wire logic [PINS-1:0] pin_i,
  input  wire logic [PINS-1:0] polarity_i,
  input  wire logic [PINS-1:0] pass_i,
  output logic      [PINS-1:0] event_o
);
  import dis_pkg::*;

  // ==========================================================================
  // Elaboration check
  if (PINS < 1 || PINS > 8) begin : g_bad
    $error("dis_ext_edge supports 1 to 8 pins");
  end

  // ==========================================================================
  // Per pin logic
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic meta_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;

    // Three stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q  <= 1'b0;
        sync2_q <= 1'b0;
        sync3_q <= 1'b0;
      end else begin
        meta_q  <= pin_i[i];
        sync2_q <= meta_q;
        sync3_q <= sync2_q;
      end
    end

    // Accept a new level once stages two and three agree; pulse on the chosen edge
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        level_q    <= 1'b0;
        event_o[i] <= 1'b0;
      end else begin
        event_o[i] <= 1'b0;
        if (sync2_q == sync3_q && sync2_q != level_q) begin
          level_q    <= sync2_q;
          event_o[i] <= pass_i[i] & (sync2_q != polarity_i[i]);  // [RQ12] [RQ14]
        end
      end
    end

    // Edge pulse only after a settled change of the chosen direction
    property p_edge_cause;
      @(posedge clock_i) disable iff (rst_i)
        event_o[i] |-> $past(sync2_q) == $past(sync3_q) && level_q != $past(polarity_i[i]);
    endproperty
    a_edge_cause: assert property (p_edge_cause) else $error("edge event without valid edge");  // [RQ12]
  end

endmodule

// ### hw/dis_pkg.sv
// Constants, register map and reset values of the interrupt source selector
package dis_pkg;

  // ==========================================================================
  // Line structure
  localparam int unsigned NUM_LINES      = 16;  // Lines presented to the core
  localparam int unsigned FIRST_MASKABLE = 4;   // Lines 0..3 are fixed
  localparam int unsigned NUM_SEL        = 12;  // Selectable lines 4..15
  localparam int unsigned FIELDS_PER_REG = 6;   // Selector fields per register
  localparam int unsigned SEL_W          = 5;   // Width of one selector code
  localparam int unsigned EXT_PINS       = 4;   // External interrupt pins 4..7
  localparam int unsigned SYNC_STAGES    = 3;   // Pin synchroniser depth

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] ADDR_SEL_HIGH   = 32'h019c0000;
  localparam logic [31:0] ADDR_SEL_LOW    = 32'h019c0004;
  localparam logic [31:0] ADDR_CTRL       = 32'h019c0008;
  localparam logic [31:0] ADDR_GPIO_CFG   = 32'h019c000c;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h019c0010;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h019c0014;
  localparam logic [31:0] ADDR_LINE_STATE = 32'h019c0018;

  // ==========================================================================
  // Field positions
  localparam int unsigned FIELD_LSB [FIELDS_PER_REG] = '{0, 5, 10, 16, 21, 26};
  localparam int unsigned CTRL_GIE_BIT  = 0;
  localparam int unsigned CFG_POL_LSB   = 0;   // Active edge per pin
  localparam int unsigned CFG_PEN_LSB   = 4;   // Pin enable per pin
  localparam int unsigned CFG_DIR_LSB   = 8;   // Direction per pin, 1 = output
  localparam int unsigned CFG_GATE_LSB  = 12;  // Event pass per pin

  // ==========================================================================
  // Source codes
  localparam logic [SEL_W-1:0] SRC_NONE   = 5'h00;
  localparam logic [SEL_W-1:0] SRC_TIMER0 = 5'h01;
  localparam logic [SEL_W-1:0] SRC_GPIO0  = 5'h10;

  // ==========================================================================
  // Values after reset
  localparam logic [SEL_W-1:0] SEL_RESET [NUM_SEL] = '{
    5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02};
  localparam logic                 GIE_RESET  = 1'b0;
  localparam logic [EXT_PINS-1:0]  POL_RESET  = 4'h0;
  localparam logic [EXT_PINS-1:0]  PEN_RESET  = 4'h0;
  localparam logic [EXT_PINS-1:0]  DIR_RESET  = 4'h0;
  localparam logic [EXT_PINS-1:0]  GATE_RESET = 4'hf;
  localparam logic [NUM_LINES-1:0] MASK_RESET = 16'h0000;

endpackage

// ### hw/dis_top.sv
// Interrupt source selector with APB registers and external pin events
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

//
// Operation
// RQ1: Sixteen prioritised lines go to the core
// RQ2: Line 0 highest priority, line 15 lowest
// RQ3: Lines 0-3 fixed: reset, NMI, two empty
// RQ4: Lines 4-15 maskable, source chosen by code
// RQ5: Selectors at 0x019c0000 and 0x019c0004, read/write
// RQ6: Low selector holds lines 4-9 fields
// RQ7: High selector holds lines 10-15 fields
// RQ8: Selector fields reset to fixed default mapping
// RQ9: Codes 1-8: timers, memory, GPIO 4-7, DMA
// RQ10: Codes 9-16: emulation, serial ports, GPIO 0
// RQ11: GPIO events 4-7 come from pins 4-7
// RQ12: Pin events edge detected, polarity bit each
// RQ13: Software enables pins as inputs first
// RQ14: GPIO controls may gate pin events
// RQ15: Line follows selected event; unused codes inactive
// RQ16: Bits 15 and 31 read zero, writes ignored
// RQ17: Global enable blocks maskable lines, resets zero
module dis_top (
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [31:0]                   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic [dis_pkg::EXT_PINS-1:0]  external_irq_pin_i,
  input  wire logic                          core_reset_req_i,
  input  wire logic                          nmi_event_i,
  input  wire logic                          timer0_event_i,
  input  wire logic                          timer1_event_i,
  input  wire logic                          memif_event_i,
  input  wire logic                          dma_done_event_i,
  input  wire logic                          emu_transfer_event_i,
  input  wire logic                          emu_rx_event_i,
  input  wire logic                          emu_tx_event_i,
  input  wire logic                          sport0_tx_event_i,
  input  wire logic                          sport0_rx_event_i,
  input  wire logic                          sport1_tx_event_i,
  input  wire logic                          sport1_rx_event_i,
  input  wire logic                          gpio_event_pin0_i,
  output logic      [dis_pkg::NUM_LINES-1:0] core_int_o,
  output logic                               irq_o
);
  import dis_pkg::*;

  // ==========================================================================
  // Elaboration check
  if (NUM_LINES != FIRST_MASKABLE + NUM_SEL || NUM_SEL != 2 * FIELDS_PER_REG) begin : g_bad
    $error("dis_top line and field counts disagree");
  end

  // ==========================================================================
  // Declarations
  logic [SEL_W-1:0]     sel_q [NUM_SEL];
  logic                 global_irq_enable_q;
  logic [EXT_PINS-1:0]  ext_irq_polarity_q;
  logic [EXT_PINS-1:0]  gpio_pin_enable_q;
  logic [EXT_PINS-1:0]  gpio_direction_q;
  logic [EXT_PINS-1:0]  gpio_gate_q;
  logic [NUM_LINES-1:0] status_q;
  logic [NUM_LINES-1:0] status_d;
  logic [NUM_LINES-1:0] mask_q;
  logic [NUM_LINES-1:0] line_set_w;
  logic [EXT_PINS-1:0]  gpio_pass_w;
  logic [EXT_PINS-1:0]  gpio_event_w;
  logic [31:0]          src_w;
  logic [NUM_SEL-1:0]   sel_line_w;
  logic [31:0]          rd_w;
  logic                 hit_w;
  logic                 setup_w;
  logic                 done_w;
  logic                 wr_w;

  // ==========================================================================
  // External pin events
  // A pin produces events only while enabled, set as input and passed
  assign gpio_pass_w = gpio_pin_enable_q & ~gpio_direction_q & gpio_gate_q;  // [RQ13] [RQ14]

  // Pins 4..7 become GPIO events 4..7
  dis_ext_edge #(
    .PINS (EXT_PINS)
  ) u_ext_edge (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .pin_i      (external_irq_pin_i),
    .polarity_i (ext_irq_polarity_q),
    .pass_i     (gpio_pass_w),
    .event_o    (gpio_event_w)  // [RQ11]
  );

  // ==========================================================================
  // Source table, indexed by selector code
  // Code 0 and codes above 16 select a constant zero
  assign src_w = {15'h0000,             // Codes 31..17: no source
                  gpio_event_pin0_i,    // 16: GPIO pin 0
                  sport1_rx_event_i,    // 15
                  sport1_tx_event_i,    // 14
                  sport0_rx_event_i,    // 13
                  sport0_tx_event_i,    // 12
                  emu_tx_event_i,       // 11
                  emu_rx_event_i,       // 10
                  emu_transfer_event_i, // 9
                  dma_done_event_i,     // 8
                  gpio_event_w,         // 7..4: GPIO pins 7..4
                  memif_event_i,        // 3
                  timer1_event_i,       // 2
                  timer0_event_i,       // 1
                  1'b0};                // 0: no source  [RQ9] [RQ10] [RQ15]

  // One multiplexer per maskable line
  for (genvar k = 0; k < NUM_SEL; k++) begin : g_mux
    assign sel_line_w[k] = src_w[sel_q[k]];  // [RQ4] [RQ15]
  end

  // ==========================================================================
  // Core interrupt lines
  // Lower index means higher priority at the core; lines 0..3 bypass the selector
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      core_int_o <= '0;
    end else begin
      core_int_o[0]   <= core_reset_req_i;  // [RQ1] [RQ2] [RQ3]
      core_int_o[1]   <= nmi_event_i;       // [RQ3]
      core_int_o[3:2] <= 2'h0;              // [RQ3]
      core_int_o[NUM_LINES-1:FIRST_MASKABLE] <=
        sel_line_w & {NUM_SEL{global_irq_enable_q}};  // [RQ4] [RQ15] [RQ17]
    end
  end

  // ==========================================================================
  // APB slave decode
  assign setup_w = psel_i & ~penable_i;
  assign done_w  = psel_i & penable_i & pready_o;
  assign wr_w    = done_w & pwrite_i;

  // Pack six selector fields into one register image; gaps read zero
  function automatic logic [31:0] pack_sel(input int unsigned base);
    logic [31:0] img;
    img = 32'h00000000;
    for (int unsigned f = 0; f < FIELDS_PER_REG; f++) begin
      img[FIELD_LSB[f] +: SEL_W] = sel_q[base + f];
    end
    return img;  // [RQ16]
  endfunction

  // Read image and address hit
  always_comb begin
    rd_w  = 32'h00000000;
    hit_w = 1'b1;
    unique case (paddr_i)
      ADDR_SEL_HIGH:   rd_w = pack_sel(FIELDS_PER_REG);  // [RQ5] [RQ7]
      ADDR_SEL_LOW:    rd_w = pack_sel(0);               // [RQ5] [RQ6]
      ADDR_CTRL:       rd_w[CTRL_GIE_BIT] = global_irq_enable_q;
      ADDR_GPIO_CFG:   rd_w[15:0] = {gpio_gate_q, gpio_direction_q, gpio_pin_enable_q, ext_irq_polarity_q};
      ADDR_IRQ_STATUS: rd_w[NUM_LINES-1:0] = status_q;
      ADDR_IRQ_MASK:   rd_w[NUM_LINES-1:0] = mask_q;
      ADDR_LINE_STATE: rd_w[NUM_LINES-1:0] = core_int_o;
      default:         hit_w = 1'b0;
    endcase
  end

  // No wait state: data and ready are registered in the setup cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= setup_w;
      pslverr_o <= setup_w & ~hit_w;
      if (setup_w) begin
        prdata_o <= pwrite_i ? 32'h00000000 : rd_w;
      end
    end
  end

  // ==========================================================================
  // Selector registers
  for (genvar k = 0; k < NUM_SEL; k++) begin : g_sel
    localparam logic [31:0] ADDR = (k < FIELDS_PER_REG) ? ADDR_SEL_LOW : ADDR_SEL_HIGH;
    localparam int unsigned LSB  = FIELD_LSB[k % FIELDS_PER_REG];

    // Only the five field bits are stored; bits 15 and 31 have no flop
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        sel_q[k] <= SEL_RESET[k];  // [RQ8]
      end else if (wr_w && paddr_i == ADDR) begin
        sel_q[k] <= pwdata_i[LSB +: SEL_W];  // [RQ5] [RQ6] [RQ7] [RQ16]
      end
    end
  end

  // ==========================================================================
  // Control and GPIO configuration registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      global_irq_enable_q <= GIE_RESET;  // [RQ17]
    end else if (wr_w && paddr_i == ADDR_CTRL) begin
      global_irq_enable_q <= pwdata_i[CTRL_GIE_BIT];
    end
  end

  // Pin polarity, enable, direction and event pass bits
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext_irq_polarity_q <= POL_RESET;
      gpio_pin_enable_q  <= PEN_RESET;
      gpio_direction_q   <= DIR_RESET;
      gpio_gate_q        <= GATE_RESET;
    end else if (wr_w && paddr_i == ADDR_GPIO_CFG) begin
      ext_irq_polarity_q <= pwdata_i[CFG_POL_LSB +: EXT_PINS];  // [RQ12]
      gpio_pin_enable_q  <= pwdata_i[CFG_PEN_LSB +: EXT_PINS];
      gpio_direction_q   <= pwdata_i[CFG_DIR_LSB +: EXT_PINS];
      gpio_gate_q        <= pwdata_i[CFG_GATE_LSB +: EXT_PINS];  // [RQ14]
    end
  end

  // ==========================================================================
  // Sticky status, mask and interrupt output
  // Status records the selected source of lines 4..15 before the global enable, and reset and NMI on lines 0 and 1
  assign line_set_w = {sel_line_w, 2'b00, nmi_event_i, core_reset_req_i};

  // Write one to clear; a new event in the same cycle wins
  always_comb begin
    status_d = status_q;
    if (wr_w && paddr_i == ADDR_IRQ_STATUS) begin
      status_d = status_q & ~pwdata_i[NUM_LINES-1:0];
    end
    status_d = status_d | line_set_w;
  end

  // Status register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Mask register, same layout as status
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= MASK_RESET;
    end else if (wr_w && paddr_i == ADDR_IRQ_MASK) begin
      mask_q <= pwdata_i[NUM_LINES-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  // ==========================================================================
  // Checks
  property p_fixed_lines;
    @(posedge clock_i) disable iff (rst_i)
      core_int_o[3:2] == 2'h0 && core_int_o[1] == $past(nmi_event_i) && core_int_o[0] == $past(core_reset_req_i);
  endproperty
  a_fixed_lines: assert property (p_fixed_lines) else $error("fixed lines 0-3 wrong");  // [RQ3]

  property p_line4_follows;
    @(posedge clock_i) disable iff (rst_i)
      global_irq_enable_q |=> core_int_o[4] == $past(src_w[sel_q[0]]);
  endproperty
  a_line4_follows: assert property (p_line4_follows) else $error("line 4 not the selected source");  // [RQ15]

  property p_line15_follows;
    @(posedge clock_i) disable iff (rst_i)
      global_irq_enable_q |=> core_int_o[15] == $past(src_w[sel_q[11]]);
  endproperty
  a_line15_follows: assert property (p_line15_follows) else $error("line 15 not the selected source");  // [RQ4]

  property p_gie_blocks;
    @(posedge clock_i) disable iff (rst_i)
      !global_irq_enable_q |=> core_int_o[15:4] == 12'h000;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks) else $error("maskable line active with enable off");  // [RQ17]

  property p_code_none;
    @(posedge clock_i) disable iff (rst_i)
      sel_q[9] == SRC_NONE |=> !core_int_o[13];
  endproperty
  a_code_none: assert property (p_code_none) else $error("code zero drove line 13");  // [RQ15]

  property p_reset_map;
    @(posedge clock_i) disable iff (rst_i)
      $past(rst_i) |-> sel_q[0] == 5'h04 && sel_q[6] == 5'h03 && sel_q[10] == SRC_TIMER0 && !global_irq_enable_q;
  endproperty
  a_reset_map: assert property (p_reset_map) else $error("selector defaults wrong after reset");  // [RQ8]

  property p_reserved_zero;
    @(posedge clock_i) disable iff (rst_i)
      pready_o && (paddr_i == ADDR_SEL_HIGH || paddr_i == ADDR_SEL_LOW) |->
        prdata_o[15] == 1'b0 && prdata_o[31] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("bit 15 or 31 read as one");  // [RQ16]

  property p_high_write;
    @(posedge clock_i) disable iff (rst_i)
      wr_w && paddr_i == ADDR_SEL_HIGH |=> sel_q[6] == $past(pwdata_i[4:0]) && sel_q[11] == $past(pwdata_i[30:26]);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high selector write lost");  // [RQ7]

  property p_low_write;
    @(posedge clock_i) disable iff (rst_i)
      wr_w && paddr_i == ADDR_SEL_LOW |=> sel_q[3] == $past(pwdata_i[20:16]);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low selector write lost");  // [RQ6]

  property p_set_wins;
    @(posedge clock_i) disable iff (rst_i)
      line_set_w[5] |=> status_q[5];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");

  property p_irq_level;
    @(posedge clock_i) disable iff (rst_i)
      irq_o == $past(|(status_q & mask_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output not the masked status");

  property p_pin_gate;
    @(posedge clock_i) disable iff (rst_i)
      !gpio_pass_w[0] |=> !gpio_event_w[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin event passed while blocked");  // [RQ13] [RQ14]

  property p_apb_answer;
    @(posedge clock_i) disable iff (rst_i)
      setup_w |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong");  // [RQ5]

endmodule

// ### sim/dis_src_model.sv
// Peripheral event source model for the selectable event inputs
`timescale 1ns/1ps

module dis_src_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [16:0] req_i,
  output logic      [16:0] event_o
);
  // ==========================================================================
  // Events
  // Bit n carries the event of selector code n, raised just after an edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      event_o <= 17'h00000;
    end else begin
      event_o <= req_i;
    end
  end
endmodule

// ### sim/dis_top_test.sv
// Self-checking testbench of the interrupt source selector
`timescale 1ns/1ps

module dis_top_test;
  import dis_pkg::*;
  typedef struct {logic [4:0] code; logic [16:0] req; logic exp;} dis_row_t;
  logic        clock_i, rst_i, psel, penable, pwrite, pready, pslverr, irq, rst_req, nmi, err;
  logic [31:0] paddr, pwdata, prdata, rd, def_hi, def_lo;
  logic [3:0]  pins;
  logic [16:0] req, evt;
  logic [15:0] lines;
  int          errors, tests_run, i, n;
  dis_row_t    rows [15];

  // ==========================================================================
  // Design and source model
  dis_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .external_irq_pin_i(pins), .core_reset_req_i(rst_req), .nmi_event_i(nmi), .timer0_event_i(evt[1]),
    .timer1_event_i(evt[2]), .memif_event_i(evt[3]), .dma_done_event_i(evt[8]),
    .emu_transfer_event_i(evt[9]), .emu_rx_event_i(evt[10]), .emu_tx_event_i(evt[11]),
    .sport0_tx_event_i(evt[12]), .sport0_rx_event_i(evt[13]), .sport1_tx_event_i(evt[14]),
    .sport1_rx_event_i(evt[15]), .gpio_event_pin0_i(evt[16]), .core_int_o(lines), .irq_o(irq));
  dis_src_model src_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .event_o(evt));

  // ==========================================================================
  // Tasks
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high at a rising edge
  task automatic apb(logic wr, logic [31:0] addr, logic [31:0] wdata);
    int k = 0;
    @(posedge clock_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= wdata;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    check("pready", {31'h0, pready}, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Raise sources, compare masked lines, then drop the sources
  task automatic fire_chk(string name, logic [16:0] m, logic [15:0] mask, logic [15:0] exp);
    @(posedge clock_i);
    req <= m;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    check(name, {16'h0000, lines & mask}, {16'h0000, exp});
    @(posedge clock_i);
    req <= 17'h00000;
    repeat (3) @(posedge clock_i);
  endtask

  // Count cycles in which a line is high after a pin change
  task automatic pin_cnt(logic [3:0] p, output int cnt);
    cnt = 0;
    @(posedge clock_i);
    pins <= p;
    repeat (14) begin
      @(negedge clock_i);
      if (lines[4] === 1'b1) cnt++;
    end
  endtask

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  initial begin
    #(50 * 6000);
    errors++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pins = 4'h0; req = 17'h00000; rst_req = 1'b0; nmi = 1'b0; errors = 0; tests_run = 0;
    def_hi = 32'h0;
    def_lo = 32'h0;
    for (i = 0; i < 6; i++) begin
      def_lo |= 32'(SEL_RESET[i]) << FIELD_LSB[i];
      def_hi |= 32'(SEL_RESET[i + 6]) << FIELD_LSB[i];
    end
    for (i = 0; i < 12; i++) begin
      rows[i].code = (i < 3) ? 5'(i + 1) : 5'(i + 5);
      rows[i].req  = 17'h00001 << rows[i].code;
      rows[i].exp  = 1'b1;
    end
    rows[12] = '{5'h00, 17'h1ffff, 1'b0};
    rows[13] = '{5'h11, 17'h1ffff, 1'b0};
    rows[14] = '{5'h1f, 17'h1ffff, 1'b0};
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    // Reset values and fixed lines with the global enable off
    apb(1'b0, ADDR_SEL_LOW, 32'h0);
    check("sel_low_reset", rd, def_lo);
    apb(1'b0, ADDR_SEL_HIGH, 32'h0);
    check("sel_high_reset", rd, def_hi);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    rst_req <= 1'b1;
    nmi <= 1'b1;
    fire_chk("lines_gie_off", 17'h1ffff, 16'hffff, 16'h0003);
    rst_req <= 1'b0;
    nmi <= 1'b0;
    $display("Test reset and fixed lines done");
    // Register access, unused bits and unmapped address
    apb(1'b1, ADDR_SEL_LOW, 32'hffffffff);
    apb(1'b0, ADDR_SEL_LOW, 32'h0);
    check("sel_low_ones", rd, 32'h7fff7fff);
    apb(1'b1, ADDR_SEL_HIGH, 32'hffffffff);
    apb(1'b0, ADDR_SEL_HIGH, 32'h0);
    check("sel_high_ones", rd, 32'h7fff7fff);
    apb(1'b0, 32'h019c0020, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, ADDR_SEL_LOW, def_lo);
    apb(1'b1, ADDR_CTRL, 32'h1);
    $display("Test register access done");
    // Selector codes 0-3, 8-17 and 31 steered onto line 14
    foreach (rows[r]) begin
      apb(1'b1, ADDR_SEL_HIGH, (def_hi & ~(32'h1f << 21)) | (32'(rows[r].code) << 21));
      fire_chk("line14_code", rows[r].req, 16'h4000, {1'b0, rows[r].exp, 14'h0});
    end
    apb(1'b1, ADDR_SEL_HIGH, def_hi);
    $display("Test selector codes done");
    // Sticky status, mask and interrupt output
    apb(1'b1, ADDR_IRQ_STATUS, 32'hffff);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4000);
    fire_chk("line14_timer0", 17'h00002, 16'hfff0, 16'h4000);
    check("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("status", rd, 32'h4000);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(negedge clock_i);
    check("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4000);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h4000);
    repeat (2) @(negedge clock_i);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    $display("Test interrupt output done");
    // External pin events on line 4
    apb(1'b1, ADDR_GPIO_CFG, 32'hf0f0);
    pin_cnt(4'h1, n);
    check("pin_rise", 32'(n), 32'h1);
    apb(1'b1, ADDR_GPIO_CFG, 32'hf0f1);
    pin_cnt(4'h0, n);
    check("pin_fall", 32'(n), 32'h1);
    apb(1'b1, ADDR_GPIO_CFG, 32'he0f0);
    pin_cnt(4'h1, n);
    check("pin_gated", 32'(n), 32'h0);
    apb(1'b1, ADDR_GPIO_CFG, 32'hf1f0);
    pin_cnt(4'h0, n);
    pin_cnt(4'h1, n);
    check("pin_output", 32'(n), 32'h0);
    $display("Test external pins done");
    // Reset in mid-run restores the defaults
    apb(1'b1, ADDR_SEL_LOW, 32'hffffffff);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, ADDR_SEL_LOW, 32'h0);
    check("sel_low_rerun", rd, def_lo);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl_rerun", rd, 32'h0);
    apb(1'b0, ADDR_GPIO_CFG, 32'h0);
    check("gpio_cfg_rerun", rd, 32'(GATE_RESET) << CFG_GATE_LSB);
    $display("Test mid-run reset done");
    give_verdict();
  end
endmodule
